// >>> core/scpt_defs.svh
// offsets, field positions, reset values and timing counts of the clock prescale and trim block
`ifndef SCPT_DEFS_SVH
`define SCPT_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SCPT_IDX_PRESCALE   10'h061
`define SCPT_IDX_TRIM       10'h066
`define SCPT_IDX_TOSC       10'h067

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define SCPT_PCE_BIT        7
`define SCPT_PCE_UNLOCK     8'h80
`define SCPT_PS_RST_NODIV   4'h0
`define SCPT_PS_RST_DIV8    4'h3
`define SCPT_PS_MAX         4'h8
`define SCPT_TRIM_RANGE_BIT 7
`define SCPT_TOSC_EN_BIT    0
`define SCPT_TOSC_EXT_BIT   1
`define SCPT_STAT_TOSC_BIT  4
`define SCPT_STAT_RUN_BIT   5

// ----------------------------------------------------------------
// start-up delay codes
// ----------------------------------------------------------------
`define SCPT_SDS_BROWNOUT   2'h0
`define SCPT_SDS_FAST       2'h1
`define SCPT_SDS_SLOW       2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCPT_CLK_HZ         20000000
`define SCPT_T_FAST_US      4000
`define SCPT_T_SLOW_US      65000
`define SCPT_RESET_CK       21'h00000E
`define SCPT_WAKE_CK        21'h000006
`define SCPT_PCE_TIMEOUT    3'h4

`endif

// >>> core/scpt_pkg.sv
// types shared by the clock prescale and trim block
`default_nettype none
package scpt_pkg;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } scpt_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scpt_apb_rsp_t;

    // clock enables of the divided domains
    typedef struct packed {
        logic io;
        logic adc;
        logic cpu;
        logic flash;
    } scpt_clk_en_t;

    typedef enum logic [2:0] {
        SCPT_BOOT_LOAD,
        SCPT_BOOT_DELAY,
        SCPT_RUN,
        SCPT_SLEEP,
        SCPT_WAKE
    } scpt_boot_e;

    // divider state
    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] act;
        logic       lvl;
    } scpt_div_st_t;

    // main block state
    typedef struct packed {
        scpt_boot_e  boot;
        logic [20:0] dly;
        logic        pce;
        logic [2:0]  pce_cnt;
        logic [3:0]  ps;
        logic [7:0]  trim;
        logic        tosc_en;
        logic        ext_en;
        logic [31:0] rdata;
    } scpt_main_st_t;

endpackage : scpt_pkg
`default_nettype wire

// >>> core/scpt_div.sv
// glitch-free power-of-two divider producing a tick and a square level
`timescale 1ns/100ps
`default_nettype none
`include "scpt_defs.svh"

module scpt_div
    import scpt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] code,
    output logic            tick,
    output logic            level,
    output logic            factor_one
);
    scpt_div_st_t s_r;
    scpt_div_st_t s_nxt;
    logic [3:0]   req;
    logic [8:0]   span;
    logic [8:0]   span_nxt;
    logic [7:0]   limit;

    // reserved codes clamped
    // reserved codes run at the largest factor
    assign req   = (code > `SCPT_PS_MAX) ? `SCPT_PS_MAX : code;
    assign span  = 9'h001 << s_r.act;
    assign limit = 8'(span - 9'h001);
    assign tick  = (s_r.cnt == limit);
    assign level = s_r.lvl;
    assign factor_one = (s_r.act == 4'h0);

    // switch at period end
    // a new factor is adopted only at the end of a whole period
    always_comb
    begin
        s_nxt = s_r;
        if (tick)
        begin
            s_nxt.cnt = 8'h00;
            s_nxt.act = req;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
        span_nxt  = 9'h001 << s_nxt.act;
        s_nxt.lvl = ({1'b0, s_nxt.cnt} < {1'b0, span_nxt[8:1]});
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

endmodule : scpt_div
`default_nettype wire

// >>> core/scpt_top.sv
// system clock prescaler, start-up timing, clock output and rc trim
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "scpt_defs.svh"


// ----------------------------------------------------------------
// block notes
// ----------------------------------------------------------------
// the clock pin shows pclk itself in reset and at factor one,
// so it keeps toggling before the divider has a count to show
// at larger factors the pin is the divider's square level,
// high for the first half of each divided period
// reserved select codes are stored and read back as written,
// but the divider runs them at its largest factor
// the change window counts cpu enable pulses, not source cycles,
// so at a large factor it stays open for a long time
// a second unlock write inside the window is dropped on purpose
// a select write with the window shut is dropped silently
// a select write in the timeout cycle still lands, since the
// write decode comes after the timeout in the next-state logic
// start-up and wake delays count source cycles of pclk
// reserved start-up code 11 takes the longest delay
// read data is captured in the setup cycle and held until the
// next read, so the bus always sees zero wait states
// trim and select field are reloaded on every reset, so software
// must repeat its own settings after a reset
// the timer register is a local addition holding the timer
// oscillator enables and two status bits

module scpt_top
    import scpt_pkg::*;
#(
    parameter int FAST_DLY_CYC = `SCPT_T_FAST_US * (`SCPT_CLK_HZ / 1000000),
    parameter int SLOW_DLY_CYC = `SCPT_T_SLOW_US * (`SCPT_CLK_HZ / 1000000)
)
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire scpt_apb_req_t apb_req,
    output scpt_apb_rsp_t      apb_rsp,
    input  wire logic [1:0]    startup_delay_select,
    input  wire logic          clock_output_fuse,
    input  wire logic          divide_by_eight_fuse,
    input  wire logic [7:0]    factory_trim,
    input  wire logic          sleep_req,
    input  wire logic          rc_osc_selected,
    input  wire logic          timer_osc_input,
    input  wire logic          timer_xtal_level,
    input  wire logic          gpio_out,
    input  wire logic          gpio_oe,
    output scpt_clk_en_t       clk_en,
    output logic               cpu_ready,
    output logic               clock_out_pin_o,
    output logic               clock_out_pin_oe,
    output logic               trim_range_bit,
    output logic [6:0]         trim_fine,
    output logic               timer_osc_enable,
    output logic               async_ext_clock_active,
    output logic               timer_osc_clock
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    localparam logic [20:0] FAST_CYC = 21'(FAST_DLY_CYC);
    localparam logic [20:0] SLOW_CYC = 21'(SLOW_DLY_CYC);

    // state copy and divider taps
    scpt_main_st_t s_r;
    scpt_main_st_t s_nxt;
    logic          div_tick;
    logic          div_level;
    logic          div_one;
    logic          cpu_tick;
    // bus decode
    logic          wr;
    logic          rd_setup;
    logic [9:0]    idx;
    logic          hit_ps;
    logic          hit_trim;
    logic          hit_tosc;
    logic          hit_any;
    logic [7:0]    wbyte;
    // start-up delay and pin helper
    logic [20:0]   extra;
    logic          sys_clk_level;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------

    scpt_div scpt_div_inst (
        .clk        (pclk),
        .rst_n      (presetn),
        .code       (s_r.ps),
        .tick       (div_tick),
        .level      (div_level),
        .factor_one (div_one)
    );

    assign cpu_tick     = div_tick & (s_r.boot == SCPT_RUN);
    assign clk_en.io    = cpu_tick;
    assign clk_en.adc   = cpu_tick;
    assign clk_en.cpu   = cpu_tick;
    assign clk_en.flash = cpu_tick;
    assign cpu_ready    = (s_r.boot == SCPT_RUN);

    // ----------------------------------------------------------------
    // clock output pin
    // ----------------------------------------------------------------

    // divided clock forwarded, source clock when undivided
    assign sys_clk_level = (!presetn || div_one) ? pclk : div_level;

    // fuse overrides the pin, also in reset
    assign clock_out_pin_o  = clock_output_fuse ? sys_clk_level : gpio_out;
    assign clock_out_pin_oe = clock_output_fuse | gpio_oe;

    // ----------------------------------------------------------------
    // trim and timer oscillator outputs
    // ----------------------------------------------------------------

    assign trim_range_bit = s_r.trim[`SCPT_TRIM_RANGE_BIT];
    assign trim_fine      = s_r.trim[6:0];

    // timer oscillator gated by rc system clock
    assign timer_osc_enable = s_r.tosc_en & rc_osc_selected;
    // external clock on timer input only when enabled
    assign async_ext_clock_active = timer_osc_enable & s_r.ext_en;
    assign timer_osc_clock = async_ext_clock_active ? timer_osc_input : timer_xtal_level;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------

    // address decode on word index
    assign idx      = apb_req.paddr[11:2];
    assign hit_ps   = (idx == `SCPT_IDX_PRESCALE);
    assign hit_trim = (idx == `SCPT_IDX_TRIM);
    assign hit_tosc = (idx == `SCPT_IDX_TOSC);
    assign hit_any  = hit_ps | hit_trim | hit_tosc;
    assign wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign wbyte    = apb_req.pwdata[7:0];

    // zero-wait answer, error on unmapped access
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit_any;
    assign apb_rsp.prdata  = s_r.rdata;

    // ----------------------------------------------------------------
    // start-up delay selection
    // ----------------------------------------------------------------

    always_comb
    begin
        case (startup_delay_select)
            `SCPT_SDS_BROWNOUT: extra = 21'h000000;
            `SCPT_SDS_FAST:     extra = FAST_CYC;
            `SCPT_SDS_SLOW:     extra = SLOW_CYC;
            default:            extra = SLOW_CYC;  // reserved code
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // boot sequencing, registers and read data
    always_comb
    begin
        s_nxt = s_r;

        // boot and sleep sequencing
        case (s_r.boot)
            // load fuses, trim and the delay count
            SCPT_BOOT_LOAD:
            begin
                s_nxt.ps   = divide_by_eight_fuse ? `SCPT_PS_RST_DIV8 : `SCPT_PS_RST_NODIV;
                s_nxt.trim = factory_trim;
                s_nxt.dly  = `SCPT_RESET_CK + extra - 21'h000001;
                s_nxt.boot = SCPT_BOOT_DELAY;
            end
            // count out the start-up delay
            SCPT_BOOT_DELAY:
            begin
                if (s_r.dly == 21'h000000)
                    s_nxt.boot = SCPT_RUN;
                else
                    s_nxt.dly = s_r.dly - 21'h000001;
            end
            // normal running, divided enables live
            SCPT_RUN:
            begin
                if (sleep_req)
                    s_nxt.boot = SCPT_SLEEP;
            end
            // enables held off until the wake request
            SCPT_SLEEP:
            begin
                if (!sleep_req)
                begin
                    s_nxt.dly  = `SCPT_WAKE_CK - 21'h000001;
                    s_nxt.boot = SCPT_WAKE;
                end
            end
            // count out the wake delay
            SCPT_WAKE:
            begin
                if (s_r.dly == 21'h000000)
                    s_nxt.boot = SCPT_RUN;
                else
                    s_nxt.dly = s_r.dly - 21'h000001;
            end
            // unused codes restart the boot
            default:
            begin
                s_nxt.boot = SCPT_BOOT_LOAD;
            end
        endcase

        if (s_r.pce && cpu_tick)
        begin
            if (s_r.pce_cnt == 3'h1)
                s_nxt.pce = 1'b0;
            s_nxt.pce_cnt = s_r.pce_cnt - 3'h1;
        end

        // register writes
        if (wr && hit_ps)
        begin
            if (wbyte == `SCPT_PCE_UNLOCK)
            begin
                if (!s_r.pce)
                begin
                    // set only with other bits zero
                    s_nxt.pce     = 1'b1;
                    s_nxt.pce_cnt = `SCPT_PCE_TIMEOUT;
                end
            end
            else if (!wbyte[`SCPT_PCE_BIT] && s_r.pce)
            begin
                s_nxt.ps  = wbyte[3:0];
                s_nxt.pce = 1'b0;
                s_nxt.pce_cnt = 3'h0;
            end
        end
        if (wr && hit_trim)
        begin
            s_nxt.trim = wbyte;
        end
        if (wr && hit_tosc)
        begin
            s_nxt.tosc_en = wbyte[`SCPT_TOSC_EN_BIT];
            s_nxt.ext_en  = wbyte[`SCPT_TOSC_EXT_BIT];
        end

        // read data captured in the setup cycle
        if (rd_setup)
        begin
            s_nxt.rdata = 32'h00000000;
            // prescale enable and select
            if (hit_ps)
            begin
                s_nxt.rdata[`SCPT_PCE_BIT] = s_r.pce;
                s_nxt.rdata[3:0]           = s_r.ps;
            end
            // trim byte
            if (hit_trim)
            begin
                s_nxt.rdata[7:0] = s_r.trim;
            end
            // timer control and status
            if (hit_tosc)
            begin
                s_nxt.rdata[`SCPT_TOSC_EN_BIT]   = s_r.tosc_en;
                s_nxt.rdata[`SCPT_TOSC_EXT_BIT]  = s_r.ext_en;
                s_nxt.rdata[`SCPT_STAT_TOSC_BIT] = timer_osc_enable;
                s_nxt.rdata[`SCPT_STAT_RUN_BIT]  = cpu_ready;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------

    // all block state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // constants only: boot restarts from the load state
            s_r      <= '0;
            s_r.boot <= SCPT_BOOT_LOAD;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule : scpt_top
`default_nettype wire

// >>> sim/scpt_top_monitor.sv
// concurrent checks on the ports of the clock prescale and trim block
`timescale 1ns/100ps
`default_nettype none
module scpt_top_monitor
    import scpt_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire scpt_apb_req_t apb_req,
    input wire logic          clock_output_fuse,
    input wire logic          sleep_req,
    input wire logic          rc_osc_selected,
    input wire logic          timer_osc_input,
    input wire logic          gpio_out,
    input wire logic          gpio_oe,
    input wire scpt_clk_en_t  clk_en,
    input wire logic          cpu_ready,
    input wire logic          clock_out_pin_o,
    input wire logic          clock_out_pin_oe,
    input wire logic          trim_range_bit,
    input wire logic [6:0]    trim_fine,
    input wire logic          timer_osc_enable,
    input wire logic          async_ext_clock_active,
    input wire logic          timer_osc_clock
);
    // one clock domain, reset disables every check
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    enables_alike_a : assert property ((clk_en.io == clk_en.cpu) && (clk_en.adc == clk_en.cpu)
        && (clk_en.flash == clk_en.cpu)) else $error("divided enables differ");
    enables_in_run_a : assert property (!cpu_ready |-> clk_en == '0)
        else $error("enable pulse outside run state");
    pin_enable_a : assert property (clock_out_pin_oe == (clock_output_fuse | gpio_oe))
        else $error("clock pin enable wrong");
    pin_port_a : assert property (!clock_output_fuse |-> clock_out_pin_o == gpio_out)
        else $error("clock pin not back to port function");
    timer_rc_only_a : assert property (timer_osc_enable |-> rc_osc_selected)
        else $error("timer oscillator on without rc clock");
    ext_clock_gate_a : assert property (async_ext_clock_active |-> timer_osc_enable
        && timer_osc_clock == timer_osc_input) else $error("external timer clock path wrong");
    wake_bound_a : assert property ($fell(sleep_req) |-> ##[1:8] cpu_ready)
        else $error("wake delay too long");
    trim_write_a : assert property (apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == 12'h198 |=> {trim_range_bit, trim_fine} == $past(apb_req.pwdata[7:0]))
        else $error("trim write not applied");
endmodule : scpt_top_monitor

bind scpt_top scpt_top_monitor scpt_top_monitor_inst
(
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .clock_output_fuse(clock_output_fuse),
    .sleep_req(sleep_req),
    .rc_osc_selected(rc_osc_selected),
    .timer_osc_input(timer_osc_input),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .clk_en(clk_en),
    .cpu_ready(cpu_ready),
    .clock_out_pin_o(clock_out_pin_o),
    .clock_out_pin_oe(clock_out_pin_oe),
    .trim_range_bit(trim_range_bit),
    .trim_fine(trim_fine),
    .timer_osc_enable(timer_osc_enable),
    .async_ext_clock_active(async_ext_clock_active),
    .timer_osc_clock(timer_osc_clock)
);
`default_nettype wire

// >>> sim/scpt_ext_model.sv
// far-side model: timer oscillator sources feeding the clock block
`timescale 1ns/100ps
`default_nettype none
module scpt_ext_model
(
    input  wire logic pclk,
    output logic      tosc_ext,
    output logic      tosc_xtal
);
    logic [2:0] cnt_r = 3'h0;

    // steady source rate
    // fixed division of the source, so its rate never jumps
    always_ff @(posedge pclk)
    begin
        cnt_r <= cnt_r + 3'h1;
    end
    assign tosc_ext  = cnt_r[2];
    assign tosc_xtal = ~cnt_r[2];  // always opposite the external source
endmodule : scpt_ext_model
`default_nettype wire

// >>> sim/scpt_top_tb.sv
// self-checking bench for the clock prescale and trim block
`timescale 1ns/100ps
`default_nettype none
`include "scpt_defs.svh"
module scpt_top_tb
    import scpt_pkg::*;
;
    localparam logic [11:0] A_PS = {`SCPT_IDX_PRESCALE, 2'h0};
    localparam logic [11:0] A_TR = {`SCPT_IDX_TRIM, 2'h0};
    localparam logic [11:0] A_TM = {`SCPT_IDX_TOSC, 2'h0};
    logic          pclk = 1'b0;
    logic          presetn, ck_fuse, d8_fuse, sleep, rc_sel, g_out, g_oe, err;
    logic          tosc_ext, tosc_xtal, cpu_ready, pin_o, pin_oe, trim_hi, tosc_en, ext_act, tosc_clk;
    logic [1:0]    sds;
    logic [7:0]    ftrim;
    logic [6:0]    trim_lo;
    logic [31:0]   q;
    scpt_apb_req_t req;
    scpt_apb_rsp_t rsp;
    scpt_clk_en_t  clk_en;
    int            num_errors = 0;
    int            comparisons = 0;

    // 20 MHz source clock
    always #25 pclk = ~pclk;

    scpt_top #(.FAST_DLY_CYC(20), .SLOW_DLY_CYC(40)) scpt_top_inst
    (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .startup_delay_select(sds), .clock_output_fuse(ck_fuse), .divide_by_eight_fuse(d8_fuse),
        .factory_trim(ftrim), .sleep_req(sleep), .rc_osc_selected(rc_sel), .timer_osc_input(tosc_ext),
        .timer_xtal_level(tosc_xtal), .gpio_out(g_out), .gpio_oe(g_oe), .clk_en(clk_en),
        .cpu_ready(cpu_ready), .clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe),
        .trim_range_bit(trim_hi), .trim_fine(trim_lo), .timer_osc_enable(tosc_en),
        .async_ext_clock_active(ext_act), .timer_osc_clock(tosc_clk)
    );
    scpt_ext_model scpt_ext_model_inst (.pclk(pclk), .tosc_ext(tosc_ext), .tosc_xtal(tosc_xtal));

    task automatic give_verdict();
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic unlock(input logic [31:0] c);
        apb(1'b1, A_PS, 32'h80);
        apb(1'b1, A_PS, c);
    endtask : unlock

    // cycles up to the next cpu enable pulse
    task automatic gap(output int g);
        g = 0;
        do
        begin
            @(negedge pclk);
            g++;
        end
        while (clk_en.cpu !== 1'b1 && g < 600);
    endtask : gap

    task automatic t_boot();
        int n;
        n = 0;
        repeat (11) @(posedge pclk);
        @(negedge pclk);
        chk({pin_oe, pin_o}, 2'h2);
        @(posedge pclk);
        presetn <= 1'b1;
        while (cpu_ready !== 1'b1 && n < 100)
        begin
            @(negedge pclk);
            n++;
        end
        chk(n >= 34 && n <= 38, 1);
        rd(A_PS, 32'h3);
        rd(A_TR, 32'hA5);
        chk(trim_hi, 1);
        apb(1'b0, 12'h100, 32'h0);
        chk(err, 1);
        chk(q, 0);
    endtask : t_boot

    // select codes 0 to 9, period after the switch
    task automatic t_divide();
        int g;
        for (int c = 0; c < 10; c++)
        begin
            unlock(c);
            gap(g);
            gap(g);
            chk(g, 1 << (c > 8 ? 8 : c));
            gap(g);
            chk(g, 1 << (c > 8 ? 8 : c));
            rd(A_PS, c);
        end
    endtask : t_divide

    // refused writes, then the enable window at divide by 256
    task automatic t_window();
        apb(1'b1, A_PS, 32'h81);
        apb(1'b1, A_PS, 32'h2);
        rd(A_PS, 32'h9);
        apb(1'b1, A_PS, 32'h80);
        repeat (500) @(negedge pclk);
        rd(A_PS, 32'h89);
        apb(1'b1, A_PS, 32'h80);
        rd(A_PS, 32'h89);
        repeat (600) @(negedge pclk);
        rd(A_PS, 32'h9);
        unlock(32'h3);
    endtask : t_window

    task automatic t_pins();
        int n;
        logic p;
        n = 0;
        // let the divide by 8 setting take over first
        repeat (300) @(negedge pclk);
        @(negedge pclk);
        p = pin_o;
        repeat (64)
        begin
            @(negedge pclk);
            n += (pin_o === 1'b1 && p === 1'b0);
            p = pin_o;
        end
        chk(n, 8);
        @(posedge pclk);
        ck_fuse <= 1'b0;
        g_out <= 1'b1;
        @(negedge pclk);
        chk({pin_oe, pin_o}, 2'h1);
        @(posedge pclk);
        ck_fuse <= 1'b1;
        apb(1'b1, A_TM, 32'h3);
        @(negedge pclk);
        chk({ext_act, tosc_clk}, {1'b1, tosc_ext});
        rd(A_TM, 32'h33);
        @(posedge pclk);
        rc_sel <= 1'b0;
        @(negedge pclk);
        chk({tosc_en, tosc_clk}, {1'b0, tosc_xtal});
        @(posedge pclk);
        rc_sel <= 1'b1;
        apb(1'b1, A_TR, 32'h7F);
        @(negedge pclk);
        chk({trim_hi, trim_lo}, 8'h7F);
        rd(A_TR, 32'h7F);
    endtask : t_pins

    task automatic t_sleep();
        int n;
        n = 0;
        @(posedge pclk);
        sleep <= 1'b1;
        repeat (3) @(negedge pclk);
        repeat (20)
        begin
            @(negedge pclk);
            n += (clk_en.cpu !== 1'b0);
        end
        chk(n, 0);
        @(posedge pclk);
        sleep <= 1'b0;
        n = 0;
        while (cpu_ready !== 1'b1 && n < 50)
        begin
            @(negedge pclk);
            n++;
        end
        chk(n >= 6 && n <= 9, 1);
    endtask : t_sleep

    // mid-run reset with another start-up code and the divide fuse clear
    task automatic t_reboot(input logic [1:0] code, input int cyc);
        int n;
        n = 0;
        @(posedge pclk);
        presetn <= 1'b0;
        sds <= code;
        d8_fuse <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        while (cpu_ready !== 1'b1 && n < 100)
        begin
            @(negedge pclk);
            n++;
        end
        chk(n >= cyc + 14 && n <= cyc + 18, 1);
        rd(A_PS, 32'h0);
        rd(A_TR, 32'hA5);
    endtask : t_reboot

    // main sequence
    initial
    begin
        {presetn, sleep, g_out, g_oe} = 4'h0;
        {ck_fuse, d8_fuse, rc_sel} = 3'h7;
        sds = 2'h1;
        ftrim = 8'hA5;
        req = '0;
        t_boot();
        t_divide();
        t_window();
        t_pins();
        t_reboot(2'h2, 40);
        t_reboot(2'h3, 40);
        t_reboot(2'h0, 0);
        t_sleep();
        give_verdict();
    end

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end
endmodule : scpt_top_tb
`default_nettype wire
